// ===== src/sbd_pkg.sv
// shared constants and types for the shift, logic, bit and skip datapath
// assumes one 250 MHz core clock and an 8-bit working register
package sbd_pkg;
   localparam int         DW          = 8;
   localparam int         FLAG_Z      = 0;
   localparam int         FLAG_C      = 1;
   localparam int         FLAG_AC     = 2;
   localparam int         FLAG_OV     = 3;
   localparam logic [3:0] FLAGS_RST   = 4'h0;
   localparam logic [7:0] WREG_RST    = 8'h00;
   localparam logic [7:0] ONE_BYTE    = 8'h01;
   localparam logic [7:0] ZERO_BYTE   = 8'h00;
   // instruction cycles taken by a skip whose condition holds
   localparam int         SKIP_CYCLES = 2;

   typedef enum logic [4:0] {
      OP_NOP   = 5'h00,
      OP_SHR   = 5'h01,
      OP_RRC   = 5'h02,
      OP_SHL   = 5'h03,
      OP_RLC   = 5'h04,
      OP_SWAP  = 5'h05,
      OP_AND   = 5'h06,
      OP_OR    = 5'h07,
      OP_XOR   = 5'h08,
      OP_NOT   = 5'h09,
      OP_NEG   = 5'h0A,
      OP_CMP   = 5'h0B,
      OP_BCLR  = 5'h0C,
      OP_BSET  = 5'h0D,
      OP_SWAPC = 5'h0E,
      OP_SKEQ  = 5'h0F,
      OP_SKNE  = 5'h10,
      OP_SKBL  = 5'h11,
      OP_SKBH  = 5'h12,
      OP_INCSK = 5'h13,
      OP_DECSK = 5'h14
   } sbd_op_t;

   // ACC: working register with immediate, ACC_M: working register with memory,
   // MEM: memory byte is the target (compare: memory minus working register),
   // IO: IO register is the target
   typedef enum logic [1:0] {
      FORM_ACC   = 2'h0,
      FORM_ACC_M = 2'h1,
      FORM_MEM   = 2'h2,
      FORM_IO    = 2'h3
   } sbd_form_t;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,
      ST_SKIP = 2'b10
   } sbd_state_t;
endpackage

// ===== src/sbd_addsub.sv
// add or subtract with the carry, half carry and overflow flags of the core
// assumes subtraction carry means borrow
`timescale 1ns/1ps
module sbd_addsub #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   input  wire logic         sub,
   output logic      [W-1:0] res,
   output logic              carry,
   output logic              half_carry,
   output logic              ovf
);
   logic [W-1:0] bb;
   logic [W:0]   full;
   logic [4:0]   half;

   assign bb   = sub ? ~b : b;
   assign full = {1'b0, a} + {1'b0, bb} + {{W{1'b0}}, sub};
   assign half = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
   assign res  = full[W-1:0];
   // borrow is the inverted carry out when subtracting
   assign carry      = full[W] ^ sub;
   assign half_carry = half[4] ^ sub;
   assign ovf        = (a[W-1] == bb[W-1]) && (res[W-1] != a[W-1]);
endmodule

// ===== src/sbd_bitmod.sv
// single bit read and replace within one byte
// assumes the select is always in range
`timescale 1ns/1ps
module sbd_bitmod #(
   parameter int W = 8
) (
   input  wire logic [W-1:0]         din,
   input  wire logic [$clog2(W)-1:0] sel,
   input  wire logic                 val,
   output logic      [W-1:0]         dout,
   output logic                      bit_now
);
   assign bit_now = din[sel];

   always_comb begin
      dout      = din;
      dout[sel] = val;
   end
endmodule

// ===== src/sbd_top.sv
// shift, logic, bit and conditional-skip datapath of an 8-bit core
// assumes fetch and decode present one operation per OP_VALID while OP_READY
// Overview of operation
// - right shift fills zero, bit0 to carry
// - right rotate through carry, carry only
// - memory right forms write back, carry only
// - left shift fills zero, bit7 to carry
// - left rotate through carry, carry only
// - memory left forms write back, carry only
// - nibble swap of working register
// - and/or update zero flag only
// - xor to register or memory, zero only
// - xor into IO register, flags untouched
// - ones complement in place, zero only
// - twos complement in place, zero only
// - compare sets all flags, stores nothing
// - bit clear/set, flags untouched
// - carry exchange with IO bit
// - output pin gets carry, input loads carry
// - skip when equal, subtract flags
// - skip when unequal, subtract flags
// - IO bit test skips, flags untouched
// - memory bit test skips, flags untouched
// - register inc/dec, all flags, skip zero
// - memory inc/dec, all flags, skip zero
// - met skip takes two cycles, else one
`timescale 1ns/1ps
module sbd_top (
   input  wire logic              MCLK,
   input  wire logic              RST_N,
   input  wire logic              OP_VALID,
   input  wire sbd_pkg::sbd_op_t   OP_CODE,
   input  wire sbd_pkg::sbd_form_t OP_FORM,
   input  wire logic [7:0]        OP_IMM,
   input  wire logic [2:0]        OP_BIT,
   input  wire logic [7:0]        MEM_RDATA,
   input  wire logic [7:0]        IO_RDATA,
   input  wire logic              IO_PIN_OUT,
   input  wire logic              IO_PIN_LEVEL,
   input  wire logic              W_LOAD,
   input  wire logic [7:0]        W_LOAD_DATA,
   input  wire logic              FLAG_LOAD,
   input  wire logic [3:0]        FLAG_LOAD_DATA,
   output logic                   OP_READY,
   output logic [7:0]             W_OUT,
   output logic [3:0]             FLAGS_OUT,
   output logic                   MEM_WE,
   output logic [7:0]             MEM_WDATA,
   output logic                   IO_WE,
   output logic [7:0]             IO_WDATA,
   output logic                   SKIP_NEXT
);
   logic                 rst_meta_ff;
   logic                 rst_sync_ff;
   sbd_pkg::sbd_state_t  state_ff;
   logic                 ready_ff;
   logic [7:0]           w_ff;
   logic [3:0]           flags_ff;
   logic                 mem_we_ff;
   logic [7:0]           mem_wdata_ff;
   logic                 io_we_ff;
   logic [7:0]           io_wdata_ff;
   logic                 skip_ff;

   logic                 taken;
   logic [7:0]           tgt;
   logic [7:0]           opnd;
   logic [7:0]           res;
   logic                 wr_res;
   logic                 nxt_skip;
   logic [3:0]           nxt_flags;
   logic [7:0]           add_a;
   logic [7:0]           add_b;
   logic                 add_sub;
   logic [7:0]           add_res;
   logic                 add_c;
   logic                 add_ac;
   logic                 add_ov;
   logic                 bit_val;
   logic [7:0]           bit_out;
   logic                 bit_now;
   logic                 c_now;

   // reset is released through two flops; assertion stays asynchronous
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   assign taken = OP_VALID && ready_ff;
   assign c_now = flags_ff[sbd_pkg::FLAG_C];

   // byte acted on in place: memory, IO register or working register
   always_comb begin
      unique case (OP_FORM)
         sbd_pkg::FORM_MEM: tgt = MEM_RDATA;
         sbd_pkg::FORM_IO:  tgt = IO_RDATA;
         default:           tgt = w_ff;
      endcase
   end

   // second operand of a two-operand operation
   always_comb begin
      unique case (OP_FORM)
         sbd_pkg::FORM_ACC: opnd = OP_IMM;
         sbd_pkg::FORM_IO:  opnd = IO_RDATA;
         default:           opnd = MEM_RDATA;
      endcase
   end

   // one shared adder serves compare, equality skips and inc/dec
   always_comb begin
      add_a   = tgt;
      add_b   = sbd_pkg::ONE_BYTE;
      add_sub = 1'b1;
      unique case (OP_CODE)
         sbd_pkg::OP_INCSK: add_sub = 1'b0;
         sbd_pkg::OP_DECSK: add_sub = 1'b1;
         sbd_pkg::OP_NEG: begin
            add_a = sbd_pkg::ZERO_BYTE;
            add_b = tgt;
         end
         sbd_pkg::OP_CMP: begin
            add_a = (OP_FORM == sbd_pkg::FORM_MEM) ? MEM_RDATA : w_ff;
            add_b = (OP_FORM == sbd_pkg::FORM_MEM) ? w_ff : opnd;
         end
         sbd_pkg::OP_SKEQ, sbd_pkg::OP_SKNE: begin
            add_a = w_ff;
            add_b = opnd;
         end
         default: ;
      endcase
   end

   sbd_addsub #(
      .W (sbd_pkg::DW)
   ) u_addsub (
      .a          (add_a),
      .b          (add_b),
      .sub        (add_sub),
      .res        (add_res),
      .carry      (add_c),
      .half_carry (add_ac),
      .ovf        (add_ov)
   );

   always_comb begin
      unique case (OP_CODE)
         sbd_pkg::OP_BSET:  bit_val = 1'b1;
         sbd_pkg::OP_SWAPC: bit_val = c_now;
         default:           bit_val = 1'b0;
      endcase
   end

   sbd_bitmod #(
      .W (sbd_pkg::DW)
   ) u_bitmod (
      .din     (tgt),
      .sel     (OP_BIT),
      .val     (bit_val),
      .dout    (bit_out),
      .bit_now (bit_now)
   );

   // result, write-back enable, flags and skip decision of one operation
   always_comb begin
      res       = tgt;
      wr_res    = 1'b0;
      nxt_skip  = 1'b0;
      nxt_flags = flags_ff;
      unique case (OP_CODE)
         sbd_pkg::OP_SHR: begin
            res    = {1'b0, tgt[7:1]};
            wr_res = 1'b1;
            nxt_flags[sbd_pkg::FLAG_C] = tgt[0];
         end
         sbd_pkg::OP_RRC: begin
            res    = {c_now, tgt[7:1]};
            wr_res = 1'b1;
            nxt_flags[sbd_pkg::FLAG_C] = tgt[0];
         end
         sbd_pkg::OP_SHL: begin
            res    = {tgt[6:0], 1'b0};
            wr_res = 1'b1;
            nxt_flags[sbd_pkg::FLAG_C] = tgt[7];
         end
         sbd_pkg::OP_RLC: begin
            res    = {tgt[6:0], c_now};
            wr_res = 1'b1;
            nxt_flags[sbd_pkg::FLAG_C] = tgt[7];
         end
         sbd_pkg::OP_SWAP: begin
            res    = {w_ff[3:0], w_ff[7:4]};
            wr_res = 1'b1;
         end
         sbd_pkg::OP_AND, sbd_pkg::OP_OR, sbd_pkg::OP_XOR: begin
            if (OP_CODE == sbd_pkg::OP_AND) begin
               res = w_ff & opnd;
            end else if (OP_CODE == sbd_pkg::OP_OR) begin
               res = w_ff | opnd;
            end else begin
               res = w_ff ^ opnd;
            end
            wr_res = 1'b1;
            // the IO form leaves every flag alone
            if (OP_FORM != sbd_pkg::FORM_IO) begin
               nxt_flags[sbd_pkg::FLAG_Z] = (res == sbd_pkg::ZERO_BYTE);
            end
         end
         sbd_pkg::OP_NOT: begin
            res    = ~tgt;
            wr_res = 1'b1;
            nxt_flags[sbd_pkg::FLAG_Z] = (res == sbd_pkg::ZERO_BYTE);
         end
         sbd_pkg::OP_NEG: begin
            res    = add_res;
            wr_res = 1'b1;
            nxt_flags[sbd_pkg::FLAG_Z] = (res == sbd_pkg::ZERO_BYTE);
         end
         sbd_pkg::OP_CMP, sbd_pkg::OP_SKEQ, sbd_pkg::OP_SKNE: begin
            nxt_flags = {add_ov, add_ac, add_c, add_res == sbd_pkg::ZERO_BYTE};
            if (OP_CODE == sbd_pkg::OP_SKEQ) begin
               nxt_skip = (add_res == sbd_pkg::ZERO_BYTE);
            end else if (OP_CODE == sbd_pkg::OP_SKNE) begin
               nxt_skip = (add_res != sbd_pkg::ZERO_BYTE);
            end
         end
         sbd_pkg::OP_BCLR, sbd_pkg::OP_BSET: begin
            res    = bit_out;
            wr_res = 1'b1;
         end
         sbd_pkg::OP_SWAPC: begin
            // input pin: carry takes the pin, nothing is written back
            res    = bit_out;
            wr_res = IO_PIN_OUT;
            nxt_flags[sbd_pkg::FLAG_C] = IO_PIN_OUT ? bit_now : IO_PIN_LEVEL;
         end
         sbd_pkg::OP_SKBL: nxt_skip = !bit_now;
         sbd_pkg::OP_SKBH: nxt_skip = bit_now;
         sbd_pkg::OP_INCSK, sbd_pkg::OP_DECSK: begin
            res       = add_res;
            wr_res    = 1'b1;
            nxt_flags = {add_ov, add_ac, add_c, add_res == sbd_pkg::ZERO_BYTE};
            nxt_skip  = (add_res == sbd_pkg::ZERO_BYTE);
         end
         default: ;
      endcase
   end

   // skip sequencer: a met skip holds the request port for one more cycle
   always_ff @(posedge MCLK or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         state_ff <= sbd_pkg::ST_RUN;
         ready_ff <= 1'b0;
         skip_ff  <= 1'b0;
      end else begin
         unique case (state_ff)
            sbd_pkg::ST_RUN: begin
               ready_ff <= !(taken && nxt_skip);
               skip_ff  <= taken && nxt_skip;
               if (taken && nxt_skip) begin
                  state_ff <= sbd_pkg::ST_SKIP;
               end
            end
            sbd_pkg::ST_SKIP: begin
               ready_ff <= 1'b1;
               skip_ff  <= 1'b0;
               state_ff <= sbd_pkg::ST_RUN;
            end
         endcase
      end
   end

   // working register: operations take priority over a core load
   always_ff @(posedge MCLK or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         w_ff <= sbd_pkg::WREG_RST;
      end else if (taken && wr_res && OP_FORM != sbd_pkg::FORM_MEM &&
                   OP_FORM != sbd_pkg::FORM_IO) begin
         w_ff <= res;
      end else if (W_LOAD && !taken) begin
         w_ff <= W_LOAD_DATA;
      end
   end

   always_ff @(posedge MCLK or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         flags_ff <= sbd_pkg::FLAGS_RST;
      end else if (taken) begin
         flags_ff <= nxt_flags;
      end else if (FLAG_LOAD) begin
         flags_ff <= FLAG_LOAD_DATA;
      end
   end

   // memory write-back strobe
   always_ff @(posedge MCLK or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         mem_we_ff    <= 1'b0;
         mem_wdata_ff <= sbd_pkg::ZERO_BYTE;
      end else begin
         mem_we_ff <= taken && wr_res && OP_FORM == sbd_pkg::FORM_MEM;
         if (taken && wr_res) begin
            mem_wdata_ff <= res;
         end
      end
   end

   // IO register write-back strobe
   always_ff @(posedge MCLK or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         io_we_ff    <= 1'b0;
         io_wdata_ff <= sbd_pkg::ZERO_BYTE;
      end else begin
         io_we_ff <= taken && wr_res && OP_FORM == sbd_pkg::FORM_IO;
         if (taken && wr_res) begin
            io_wdata_ff <= res;
         end
      end
   end

   assign OP_READY  = ready_ff;
   assign W_OUT     = w_ff;
   assign FLAGS_OUT = flags_ff;
   assign MEM_WE    = mem_we_ff;
   assign MEM_WDATA = mem_wdata_ff;
   assign IO_WE     = io_we_ff;
   assign IO_WDATA  = io_wdata_ff;
   assign SKIP_NEXT = skip_ff;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!rst_sync_ff);

   shr_acc_a: assert property (
      taken && OP_CODE == sbd_pkg::OP_SHR && OP_FORM == sbd_pkg::FORM_ACC |=>
      W_OUT == {1'b0, $past(w_ff[7:1])} && FLAGS_OUT[1] == $past(w_ff[0]) &&
      FLAGS_OUT[0] == $past(flags_ff[0]) && FLAGS_OUT[3:2] == $past(flags_ff[3:2]))
      else $error("right shift result or carry wrong");
   rrc_acc_a: assert property (
      taken && OP_CODE == sbd_pkg::OP_RRC && OP_FORM == sbd_pkg::FORM_ACC |=>
      W_OUT == {$past(flags_ff[1]), $past(w_ff[7:1])} && FLAGS_OUT[1] == $past(w_ff[0]))
      else $error("right rotate through carry wrong");
   mem_right_a: assert property (
      taken && OP_CODE == sbd_pkg::OP_SHR && OP_FORM == sbd_pkg::FORM_MEM |=>
      MEM_WE && MEM_WDATA == {1'b0, $past(MEM_RDATA[7:1])} && $stable(W_OUT))
      else $error("memory right shift not written back");
   shl_acc_a: assert property (
      taken && OP_CODE == sbd_pkg::OP_SHL && OP_FORM == sbd_pkg::FORM_ACC |=>
      W_OUT == {$past(w_ff[6:0]), 1'b0} && FLAGS_OUT[1] == $past(w_ff[7]))
      else $error("left shift result or carry wrong");
   rlc_mem_a: assert property (
      taken && OP_CODE == sbd_pkg::OP_RLC && OP_FORM == sbd_pkg::FORM_MEM |=>
      MEM_WE && MEM_WDATA == {$past(MEM_RDATA[6:0]), $past(flags_ff[1])} &&
      FLAGS_OUT[1] == $past(MEM_RDATA[7]))
      else $error("memory left rotate wrong");
   swap_nib_a: assert property (
      taken && OP_CODE == sbd_pkg::OP_SWAP |=> W_OUT == {$past(w_ff[3:0]), $past(w_ff[7:4])})
      else $error("nibble swap wrong");
   xor_io_a: assert property (
      taken && OP_CODE == sbd_pkg::OP_XOR && OP_FORM == sbd_pkg::FORM_IO |=>
      IO_WE && IO_WDATA == ($past(w_ff) ^ $past(IO_RDATA)) && $stable(FLAGS_OUT))
      else $error("IO xor wrong or flags moved");
   logic_zero_a: assert property (
      taken && OP_CODE == sbd_pkg::OP_AND && OP_FORM == sbd_pkg::FORM_ACC |=>
      FLAGS_OUT[0] == (W_OUT == 8'h00) && FLAGS_OUT[3:1] == $past(flags_ff[3:1]))
      else $error("and zero flag wrong");
   neg_acc_a: assert property (
      taken && OP_CODE == sbd_pkg::OP_NEG && OP_FORM == sbd_pkg::FORM_ACC |=>
      W_OUT == 8'h00 - $past(w_ff))
      else $error("negation wrong");
   cmp_store_a: assert property (
      taken && OP_CODE == sbd_pkg::OP_CMP |=> $stable(W_OUT) && !MEM_WE && !IO_WE &&
      FLAGS_OUT[0] == ($past(add_a) == $past(add_b)))
      else $error("compare stored a result");
   swapc_in_a: assert property (
      taken && OP_CODE == sbd_pkg::OP_SWAPC && !IO_PIN_OUT |=>
      !IO_WE && FLAGS_OUT[1] == $past(IO_PIN_LEVEL))
      else $error("input pin carry exchange wrong");
   skip_met_a: assert property (
      taken && nxt_skip |=> SKIP_NEXT && !OP_READY ##1 !SKIP_NEXT && OP_READY)
      else $error("met skip not two cycles");
   skip_miss_a: assert property (
      taken && !nxt_skip |=> !SKIP_NEXT && OP_READY)
      else $error("unmet skip stalled");
   skeq_cond_a: assert property (
      taken && OP_CODE == sbd_pkg::OP_SKEQ |=> SKIP_NEXT == ($past(w_ff) == $past(opnd)))
      else $error("equal skip decision wrong");
   incsk_a: assert property (
      taken && OP_CODE == sbd_pkg::OP_INCSK && OP_FORM == sbd_pkg::FORM_ACC |=>
      W_OUT == $past(w_ff) + 8'h01 && SKIP_NEXT == (W_OUT == 8'h00))
      else $error("increment skip wrong");

   skip_seen_c: cover property (taken && OP_CODE == sbd_pkg::OP_SKNE ##1 SKIP_NEXT);
   bit_io_c:    cover property (taken && OP_CODE == sbd_pkg::OP_BSET ##1 IO_WE);
   dec_zero_c:  cover property (taken && OP_CODE == sbd_pkg::OP_DECSK ##1 FLAGS_OUT[0]);
   swapc_out_c: cover property (taken && OP_CODE == sbd_pkg::OP_SWAPC && IO_PIN_OUT);
endmodule

// ===== verification/sbd_top_tb_top.sv
// self-checking bench for the shift, logic, bit and skip datapath
// assumes sbd_pkg and the design files are compiled first
`timescale 1ns/1ps
module sbd_top_tb_top;
   logic               MCLK, RST_N, OP_VALID, IO_PIN_OUT, IO_PIN_LEVEL, W_LOAD, FLAG_LOAD;
   logic               OP_READY, MEM_WE, IO_WE, SKIP_NEXT;
   sbd_pkg::sbd_op_t   OP_CODE;
   sbd_pkg::sbd_form_t OP_FORM;
   logic [7:0]         OP_IMM, MEM_RDATA, IO_RDATA, W_LOAD_DATA, W_OUT, MEM_WDATA, IO_WDATA;
   logic [2:0]         OP_BIT;
   logic [3:0]         FLAG_LOAD_DATA, FLAGS_OUT, e_f;
   logic [7:0]         e_w;
   logic               e_rdy;
   int                 miscompares, samples_checked;

   sbd_top i_sbd_top (
      .MCLK(MCLK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_FORM(OP_FORM),
      .OP_IMM(OP_IMM), .OP_BIT(OP_BIT), .MEM_RDATA(MEM_RDATA), .IO_RDATA(IO_RDATA),
      .IO_PIN_OUT(IO_PIN_OUT), .IO_PIN_LEVEL(IO_PIN_LEVEL), .W_LOAD(W_LOAD),
      .W_LOAD_DATA(W_LOAD_DATA), .FLAG_LOAD(FLAG_LOAD), .FLAG_LOAD_DATA(FLAG_LOAD_DATA),
      .OP_READY(OP_READY), .W_OUT(W_OUT), .FLAGS_OUT(FLAGS_OUT), .MEM_WE(MEM_WE),
      .MEM_WDATA(MEM_WDATA), .IO_WE(IO_WE), .IO_WDATA(IO_WDATA), .SKIP_NEXT(SKIP_NEXT));

   initial begin
      MCLK = 1'b0;
      forever #2 MCLK = ~MCLK;
   end

   localparam sbd_pkg::sbd_form_t F_ACC = sbd_pkg::FORM_ACC, F_ACM = sbd_pkg::FORM_ACC_M;
   localparam sbd_pkg::sbd_form_t F_MEM = sbd_pkg::FORM_MEM, F_IO = sbd_pkg::FORM_IO;

   task automatic tally(input logic ok, input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (!ok) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      tally(g === e, g, e);
   endtask

   task automatic chk_flags(input logic [3:0] g, input logic [3:0] e);
      tally(g === e, {4'h0, g}, {4'h0, e});
   endtask

   task automatic chk_bit(input logic g, input logic e);
      tally(g === e, {7'h00, g}, {7'h00, e});
   endtask

   // {ov, ac, c, z, result}; carry and half carry mean borrow when subtracting
   function automatic logic [11:0] as_f(input logic [7:0] x, input logic [7:0] y, input logic s);
      logic [8:0] t;
      logic [4:0] h;
      t = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
      h = s ? {1'b0, x[3:0]} - {1'b0, y[3:0]} : {1'b0, x[3:0]} + {1'b0, y[3:0]};
      return {((x[7] ^ y[7]) == s) && (t[7] != x[7]), h[4], t[8], t[7:0] == 8'h00, t[7:0]};
   endfunction

   // maps a random form onto one that the operation has
   function automatic sbd_pkg::sbd_form_t legal(input sbd_pkg::sbd_op_t o,
                                                input sbd_pkg::sbd_form_t f);
      if (o == sbd_pkg::OP_SWAPC) return F_IO;
      if (o == sbd_pkg::OP_SWAP) return F_ACC;
      if (o inside {sbd_pkg::OP_BCLR, sbd_pkg::OP_BSET, sbd_pkg::OP_SKBL, sbd_pkg::OP_SKBH})
         return (f == F_IO) ? F_IO : F_MEM;
      if (o inside {sbd_pkg::OP_SKEQ, sbd_pkg::OP_SKNE}) return (f == F_ACC) ? f : F_ACM;
      if (f != F_IO || o == sbd_pkg::OP_XOR) return f;
      if (o inside {sbd_pkg::OP_AND, sbd_pkg::OP_OR}) return F_ACM;
      return F_MEM;
   endfunction

   // predict from the applied inputs, compare just after the edge
   task automatic cyc;
      logic [11:0] v;
      logic [7:0]  a, b, r, w;
      logic [3:0]  f;
      logic        tk, sk, wr, zu;
      tk = OP_VALID && e_rdy;
      w = e_w;
      f = e_f;
      {sk, wr, zu, r} = 11'h000;
      a = (OP_FORM == F_MEM) ? MEM_RDATA : (OP_FORM == F_IO) ? IO_RDATA : e_w;
      b = (OP_FORM == F_ACC) ? OP_IMM : (OP_FORM == F_IO) ? IO_RDATA : MEM_RDATA;
      v = as_f(e_w, b, 1'b1);
      if (!tk) begin
         if (W_LOAD) w = W_LOAD_DATA;
         if (FLAG_LOAD) f = FLAG_LOAD_DATA;
      end else begin
         case (OP_CODE)
            sbd_pkg::OP_SHR, sbd_pkg::OP_RRC: begin
               r = {(OP_CODE == sbd_pkg::OP_RRC) & e_f[1], a[7:1]};
               f[1] = a[0];
               wr = 1'b1;
            end
            sbd_pkg::OP_SHL, sbd_pkg::OP_RLC: begin
               r = {a[6:0], (OP_CODE == sbd_pkg::OP_RLC) & e_f[1]};
               f[1] = a[7];
               wr = 1'b1;
            end
            sbd_pkg::OP_SWAP: begin
               r = {a[3:0], a[7:4]};
               wr = 1'b1;
            end
            sbd_pkg::OP_AND, sbd_pkg::OP_OR, sbd_pkg::OP_XOR: begin
               r = (OP_CODE == sbd_pkg::OP_AND) ? e_w & b :
                   (OP_CODE == sbd_pkg::OP_OR) ? e_w | b : e_w ^ b;
               zu = OP_FORM != F_IO;
               wr = 1'b1;
            end
            sbd_pkg::OP_NOT, sbd_pkg::OP_NEG: begin
               r = (OP_CODE == sbd_pkg::OP_NOT) ? ~a : 8'h00 - a;
               zu = 1'b1;
               wr = 1'b1;
            end
            sbd_pkg::OP_CMP: begin
               if (OP_FORM == F_MEM) v = as_f(MEM_RDATA, e_w, 1'b1);
               f = v[11:8];
            end
            sbd_pkg::OP_BCLR, sbd_pkg::OP_BSET: begin
               r = a;
               r[OP_BIT] = OP_CODE == sbd_pkg::OP_BSET;
               wr = 1'b1;
            end
            sbd_pkg::OP_SWAPC: begin
               if (IO_PIN_OUT) begin
                  f[1] = a[OP_BIT];
                  r = a;
                  r[OP_BIT] = e_f[1];
                  wr = 1'b1;
               end else begin
                  f[1] = IO_PIN_LEVEL;
               end
            end
            sbd_pkg::OP_SKEQ, sbd_pkg::OP_SKNE: begin
               f = v[11:8];
               sk = (e_w == b) ^ (OP_CODE == sbd_pkg::OP_SKNE);
            end
            sbd_pkg::OP_SKBL, sbd_pkg::OP_SKBH: sk = a[OP_BIT] == (OP_CODE == sbd_pkg::OP_SKBH);
            sbd_pkg::OP_INCSK, sbd_pkg::OP_DECSK: begin
               v = as_f(a, 8'h01, OP_CODE == sbd_pkg::OP_DECSK);
               r = v[7:0];
               f = v[11:8];
               sk = r == 8'h00;
               wr = 1'b1;
            end
            default: ;
         endcase
      end
      if (zu) f[0] = r == 8'h00;
      if (wr && OP_FORM inside {F_ACC, F_ACM}) w = r;
      @(posedge MCLK);
      #1;
      chk_byte(W_OUT, w);
      chk_flags(FLAGS_OUT, f);
      chk_bit(MEM_WE, wr && OP_FORM == F_MEM);
      if (MEM_WE === 1'b1) chk_byte(MEM_WDATA, r);
      chk_bit(IO_WE, wr && OP_FORM == F_IO);
      if (IO_WE === 1'b1) chk_byte(IO_WDATA, r);
      chk_bit(SKIP_NEXT, sk);
      chk_bit(OP_READY, !sk);
      e_w = w;
      e_f = f;
      e_rdy = !sk;
   endtask

   task automatic op(input sbd_pkg::sbd_op_t o, input sbd_pkg::sbd_form_t f,
                     input logic [7:0] x, input logic [2:0] n);
      {OP_VALID, W_LOAD, FLAG_LOAD} = 3'b100;
      OP_CODE = o;
      OP_FORM = f;
      {OP_IMM, MEM_RDATA, IO_RDATA} = {3{x}};
      OP_BIT = n;
      cyc;
   endtask

   task automatic ld(input logic [7:0] w, input logic [3:0] f);
      {OP_VALID, W_LOAD, FLAG_LOAD} = 3'b011;
      {W_LOAD_DATA, FLAG_LOAD_DATA} = {w, f};
      cyc;
   endtask

   task automatic summarize;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // about 1600 cycles expected; limit is ten thousand
   initial begin
      #40000;
      miscompares++;
      summarize;
   end

   initial begin
      {RST_N, OP_VALID, IO_PIN_OUT, IO_PIN_LEVEL, W_LOAD, FLAG_LOAD} = 6'h00;
      {OP_IMM, MEM_RDATA, IO_RDATA, W_LOAD_DATA, OP_BIT, FLAG_LOAD_DATA} = 39'h0;
      OP_CODE = sbd_pkg::OP_NOP;
      OP_FORM = F_ACC;
      void'($urandom(32'hA76E));
      repeat (16) @(posedge MCLK);
      #1;
      chk_byte(W_OUT, 8'h00);
      chk_flags(FLAGS_OUT, 4'h0);
      chk_bit(SKIP_NEXT, 1'b0);
      chk_bit(OP_READY, 1'b0);
      RST_N = 1'b1;
      repeat (8) begin
         @(posedge MCLK);
         #1;
         if (OP_READY === 1'b1) break;
      end
      chk_bit(OP_READY, 1'b1);
      {e_w, e_f, e_rdy} = 13'h001;
      ld(8'h01, 4'h0);
      op(sbd_pkg::OP_SHR, F_ACC, 8'h00, 3'h0);
      op(sbd_pkg::OP_RRC, F_ACC, 8'h00, 3'h0);
      op(sbd_pkg::OP_SHR, F_MEM, 8'h81, 3'h0);
      op(sbd_pkg::OP_RRC, F_MEM, 8'h01, 3'h0);
      op(sbd_pkg::OP_SHL, F_ACC, 8'h00, 3'h0);
      op(sbd_pkg::OP_RLC, F_ACC, 8'h00, 3'h0);
      op(sbd_pkg::OP_SHL, F_MEM, 8'hFF, 3'h0);
      op(sbd_pkg::OP_RLC, F_MEM, 8'h7F, 3'h0);
      ld(8'hA5, 4'hF);
      op(sbd_pkg::OP_SWAP, F_ACC, 8'h00, 3'h0);
      op(sbd_pkg::OP_AND, F_ACC, 8'h0F, 3'h0);
      op(sbd_pkg::OP_AND, F_MEM, 8'h50, 3'h0);
      op(sbd_pkg::OP_OR, F_ACM, 8'h00, 3'h0);
      op(sbd_pkg::OP_XOR, F_ACC, 8'h0A, 3'h0);
      op(sbd_pkg::OP_XOR, F_IO, 8'hFF, 3'h0);
      op(sbd_pkg::OP_NOT, F_ACC, 8'h00, 3'h0);
      op(sbd_pkg::OP_NOT, F_MEM, 8'hFF, 3'h0);
      op(sbd_pkg::OP_NEG, F_MEM, 8'h38, 3'h0);
      ld(8'h38, 4'h0);
      op(sbd_pkg::OP_CMP, F_ACM, 8'h42, 3'h0);
      op(sbd_pkg::OP_CMP, F_MEM, 8'h38, 3'h0);
      op(sbd_pkg::OP_BCLR, F_IO, 8'hFF, 3'h7);
      op(sbd_pkg::OP_BSET, F_MEM, 8'h00, 3'h0);
      IO_PIN_OUT = 1'b1;
      op(sbd_pkg::OP_SWAPC, F_IO, 8'h01, 3'h0);
      IO_PIN_OUT = 1'b0;
      IO_PIN_LEVEL = 1'b1;
      op(sbd_pkg::OP_SWAPC, F_IO, 8'h00, 3'h3);
      op(sbd_pkg::OP_SKEQ, F_ACC, 8'h38, 3'h0);
      op(sbd_pkg::OP_SHR, F_ACC, 8'h00, 3'h0);
      op(sbd_pkg::OP_SKNE, F_ACC, 8'h38, 3'h0);
      op(sbd_pkg::OP_SKNE, F_ACM, 8'h39, 3'h0);
      ld(8'hFF, 4'h0);
      op(sbd_pkg::OP_SKBL, F_IO, 8'h80, 3'h7);
      op(sbd_pkg::OP_SKBH, F_IO, 8'h80, 3'h7);
      ld(8'hFF, 4'h0);
      op(sbd_pkg::OP_SKBH, F_MEM, 8'h01, 3'h1);
      op(sbd_pkg::OP_SKBL, F_MEM, 8'hFE, 3'h0);
      ld(8'hFF, 4'h0);
      op(sbd_pkg::OP_INCSK, F_ACC, 8'h00, 3'h0);
      ld(8'h00, 4'h0);
      op(sbd_pkg::OP_DECSK, F_ACC, 8'h00, 3'h0);
      op(sbd_pkg::OP_DECSK, F_MEM, 8'h01, 3'h0);
      $display("test directed done");
      // equal operands favoured so equality skips are often met
      repeat (1500) begin
         OP_VALID = ($urandom % 8) != 0;
         OP_CODE = sbd_pkg::sbd_op_t'(5'($urandom % 21));
         OP_FORM = legal(OP_CODE, sbd_pkg::sbd_form_t'(2'($urandom)));
         OP_IMM = (($urandom % 4) == 0) ? e_w : 8'($urandom);
         MEM_RDATA = (($urandom % 4) == 0) ? e_w : 8'($urandom);
         {IO_RDATA, OP_BIT, IO_PIN_OUT, IO_PIN_LEVEL} = 13'($urandom);
         W_LOAD = ($urandom % 4) == 0;
         FLAG_LOAD = ($urandom % 4) == 0;
         {W_LOAD_DATA, FLAG_LOAD_DATA} = 12'($urandom);
         cyc;
      end
      $display("test random done");
      summarize;
   end
endmodule
